/* hw/adso_defs.vh */
`ifndef ADSO_DEFS_VH
`define ADSO_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADSO_ADDR_CONTROL_0   8'h9A
`define ADSO_ADDR_CONTROL_1   8'h9B
`define ADSO_ADDR_STATUS      8'hC0
`define ADSO_ADDR_SAMPLE_LO   8'hC1
`define ADSO_ADDR_SAMPLE_HI   8'hC2
`define ADSO_ADDR_DIVIDER     8'hC3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADSO_C0_JUST_HI       7
`define ADSO_C0_JUST_LO       3
`define ADSO_C0_POL_BIT       2
`define ADSO_C0_SLOT_BIT      1
`define ADSO_C0_RATE_BIT      0
`define ADSO_C1_SRC_BIT       7
`define ADSO_C1_ON_BIT        0
`define ADSO_ST_HOLD_BIT      0
`define ADSO_ST_RUN_BIT       1
`define ADSO_ST_CHAN_BIT      2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ADSO_RST_CONTROL_0    8'h08
`define ADSO_RST_CONTROL_1    8'h00
`define ADSO_RST_DIVIDER      5'h00

// ----------------------------------------------------------------
// Timing counts, in half master clock periods per bit clock half, then slot and sample bit positions
// ----------------------------------------------------------------
`define ADSO_HALF_256_S16     4'h8
`define ADSO_HALF_256_S32     4'h4
`define ADSO_HALF_384_S16     4'hC
`define ADSO_HALF_384_S32     4'h6
`define ADSO_LAST_POS_S16     5'h0F
`define ADSO_LAST_POS_S32     5'h1F
`define ADSO_SAMPLE_MSB       4'hF
`define ADSO_SAMPLE_BITS      6'h10

`endif

/* hw/adso_clkdiv.v */
`timescale 1ns/10ps
module adso_clkdiv (
  input  wire       mclk,
  input  wire       sys_rst,
  input  wire       ce,
  input  wire       enable,
  input  wire [4:0] divisor,
  output reg        tick,
  output reg        master_clk_out
);

  reg [4:0] count;

  // ----------------------------------------------------------------
  // Divide by divisor plus one, toggle master clock on each tick
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      count          <= 5'h00;
      tick           <= 1'b0;
      master_clk_out <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        count          <= 5'h00;
        tick           <= 1'b0;
        master_clk_out <= 1'b0;
      end else if (count >= divisor) begin
        count          <= 5'h00;
        tick           <= 1'b1;
        master_clk_out <= ~master_clk_out;
      end else begin
        count <= count + 5'h01;
        tick  <= 1'b0;
      end
    end
  end

endmodule // adso_clkdiv

/* hw/adso_top.v */
`timescale 1ns/10ps
`include "adso_defs.vh"
module adso_top (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        ce,
  input  wire [7:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata,
  input  wire [15:0] dec_sample,
  input  wire        dec_valid,
  output wire        dec_ready,
  output wire        dac_sys_clk,
  output reg         bit_clock_out,
  output reg         word_select_out,
  output reg         audio_data_out
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function [3:0] half_ticks;
    input rate;
    input wide;
    begin
      case ({rate, wide})
        2'b00:   half_ticks = `ADSO_HALF_256_S16;
        2'b01:   half_ticks = `ADSO_HALF_256_S32;
        2'b10:   half_ticks = `ADSO_HALF_384_S16;
        default: half_ticks = `ADSO_HALF_384_S32;
      endcase
    end
  endfunction

  function slot_bit;
    input [15:0] word;
    input [4:0]  pos;
    input [4:0]  just;
    reg   [5:0]  diff;
    begin
      diff = {1'b0, pos} - {1'b0, just};
      if (pos >= just && diff < `ADSO_SAMPLE_BITS)
        slot_bit = word[`ADSO_SAMPLE_MSB - diff[3:0]];
      else
        slot_bit = 1'b0;
    end
  endfunction

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  localparam [7:0] rst_control_0 = `ADSO_RST_CONTROL_0;

  reg  [4:0]  justify_offset;
  reg         word_select_polarity;
  reg         slot_width_select;
  reg         master_rate_select;
  reg         stream_source_select;
  reg         audio_iface_on;
  reg  [4:0]  audio_clock_divisor;
  reg  [7:0]  core_lo;
  reg  [15:0] hold_word;
  reg         hold_full;
  reg  [15:0] shift_word;
  reg         running;
  reg         right_chan;
  reg  [4:0]  slot_pos;
  reg  [3:0]  phase;

  wire        tick;
  wire [3:0]  half_last;
  wire [4:0]  last_pos;
  wire        left_level;
  wire        dec_take;
  wire        core_take;
  wire        step;
  wire        half_done;
  wire        fall_edge;
  wire        slot_end;
  wire        start_frame;
  wire        load_right;
  wire        reload_left;
  wire        consume;

  // ----------------------------------------------------------------
  // Audio clock divider
  // ----------------------------------------------------------------
  adso_clkdiv u_clkdiv (
    .mclk           (mclk),
    .sys_rst        (sys_rst),
    .ce             (ce),
    .enable         (audio_iface_on),
    .divisor        (audio_clock_divisor),
    .tick           (tick),
    .master_clk_out (dac_sys_clk)
  );

  // ----------------------------------------------------------------
  // Frame timing decode
  // ----------------------------------------------------------------
  assign half_last   = half_ticks(master_rate_select, slot_width_select) - 4'h1;
  assign last_pos    = slot_width_select ? `ADSO_LAST_POS_S32
                                         : `ADSO_LAST_POS_S16;
  assign left_level  = word_select_polarity;
  assign step        = ce & tick & audio_iface_on;
  assign half_done   = step & running & (phase == half_last);
  assign fall_edge   = half_done & bit_clock_out;
  assign slot_end    = fall_edge & (slot_pos == last_pos);
  assign start_frame = step & ~running & hold_full;
  assign load_right  = slot_end & ~right_chan;
  assign reload_left = slot_end & right_chan & hold_full;
  assign consume     = start_frame | reload_left | (load_right & hold_full);

  // ----------------------------------------------------------------
  // Sample sources
  // ----------------------------------------------------------------
  // Ready only while ce is high, so a frozen cycle never loses a word
  assign dec_ready = ce & audio_iface_on & ~stream_source_select & ~hold_full;
  assign dec_take  = dec_valid & dec_ready;
  assign core_take = wr & (addr == `ADSO_ADDR_SAMPLE_HI) & audio_iface_on
                     & stream_source_select & ~hold_full;

  always @(posedge mclk) begin
    if (sys_rst) begin
      hold_word <= 16'h0000;
      hold_full <= 1'b0;
    end else if (ce) begin
      if (!audio_iface_on) begin
        hold_full <= 1'b0;
      end else if (dec_take) begin
        hold_word <= dec_sample;
        hold_full <= 1'b1;
      end else if (core_take) begin
        hold_word <= {wdata, core_lo};
        hold_full <= 1'b1;
      end else if (consume) begin
        hold_full <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      justify_offset       <= rst_control_0[`ADSO_C0_JUST_HI:`ADSO_C0_JUST_LO];
      word_select_polarity <= 1'b0;
      slot_width_select    <= 1'b0;
      master_rate_select   <= 1'b0;
      stream_source_select <= 1'b0;
      audio_iface_on       <= 1'b0;
      audio_clock_divisor  <= `ADSO_RST_DIVIDER;
      core_lo              <= 8'h00;
    end else if (ce && wr) begin
      case (addr)
        `ADSO_ADDR_CONTROL_0: begin
          justify_offset       <= wdata[`ADSO_C0_JUST_HI:`ADSO_C0_JUST_LO];
          word_select_polarity <= wdata[`ADSO_C0_POL_BIT];
          slot_width_select    <= wdata[`ADSO_C0_SLOT_BIT];
          master_rate_select   <= wdata[`ADSO_C0_RATE_BIT];
        end
        `ADSO_ADDR_CONTROL_1: begin
          stream_source_select <= wdata[`ADSO_C1_SRC_BIT];
          audio_iface_on       <= wdata[`ADSO_C1_ON_BIT];
        end
        `ADSO_ADDR_SAMPLE_LO: begin
          core_lo <= wdata;
        end
        `ADSO_ADDR_DIVIDER: begin
          audio_clock_divisor <= wdata[4:0];
        end
        default: begin
          core_lo <= core_lo;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads, data one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (ce) begin
      if (rd) begin
        case (addr)
          `ADSO_ADDR_CONTROL_0:
            rdata <= {justify_offset, word_select_polarity,
                      slot_width_select, master_rate_select};
          `ADSO_ADDR_CONTROL_1:
            rdata <= {stream_source_select, 6'h00, audio_iface_on};
          `ADSO_ADDR_STATUS:
            rdata <= {5'h00, right_chan, running, hold_full};
          `ADSO_ADDR_SAMPLE_LO:
            rdata <= core_lo;
          `ADSO_ADDR_DIVIDER:
            rdata <= {3'h0, audio_clock_divisor};
          default:
            rdata <= 8'h00;
        endcase
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serialiser and bit / word clocks
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      shift_word      <= 16'h0000;
      running         <= 1'b0;
      right_chan      <= 1'b0;
      slot_pos        <= 5'h00;
      phase           <= 4'h0;
      bit_clock_out   <= 1'b0;
      word_select_out <= 1'b0;
      audio_data_out  <= 1'b0;
    end else if (ce) begin
      if (!audio_iface_on) begin
        running         <= 1'b0;
        right_chan      <= 1'b0;
        slot_pos        <= 5'h00;
        phase           <= 4'h0;
        bit_clock_out   <= 1'b0;
        word_select_out <= left_level;
        audio_data_out  <= 1'b0;
      end else if (start_frame) begin
        // First bit is set up a full half period before the first rise
        running         <= 1'b1;
        shift_word      <= hold_word;
        right_chan      <= 1'b0;
        slot_pos        <= 5'h00;
        phase           <= 4'h0;
        bit_clock_out   <= 1'b0;
        word_select_out <= left_level;
        audio_data_out  <= slot_bit(hold_word, 5'h00, justify_offset);
      end else if (!running) begin
        bit_clock_out   <= 1'b0;
        word_select_out <= left_level;
        audio_data_out  <= 1'b0;
      end else if (step) begin
        if (!half_done) begin
          phase <= phase + 4'h1;
        end else if (!bit_clock_out) begin
          phase         <= 4'h0;
          bit_clock_out <= 1'b1;
        end else begin
          phase         <= 4'h0;
          bit_clock_out <= 1'b0;
          if (!slot_end) begin
            slot_pos       <= slot_pos + 5'h01;
            audio_data_out <= slot_bit(shift_word, slot_pos + 5'h01,
                                       justify_offset);
          end else if (!right_chan) begin
            // Right slot without a fresh sample sends silence
            slot_pos        <= 5'h00;
            right_chan      <= 1'b1;
            word_select_out <= ~left_level;
            shift_word      <= hold_full ? hold_word : 16'h0000;
            audio_data_out  <= slot_bit(hold_full ? hold_word : 16'h0000,
                                        5'h00, justify_offset);
          end else if (hold_full) begin
            slot_pos        <= 5'h00;
            right_chan      <= 1'b0;
            word_select_out <= left_level;
            shift_word      <= hold_word;
            audio_data_out  <= slot_bit(hold_word, 5'h00, justify_offset);
          end else begin
            // No sample waiting at frame end: park the clocks
            running         <= 1'b0;
            right_chan      <= 1'b0;
            slot_pos        <= 5'h00;
            word_select_out <= left_level;
            audio_data_out  <= 1'b0;
          end
        end
      end
    end
  end

endmodule // adso_top

/* bench/adso_top_asserts.sv */
`timescale 1ns/10ps
`include "adso_defs.vh"
module adso_top_asserts (
  input wire        mclk,
  input wire        sys_rst,
  input wire        ce,
  input wire [7:0]  addr,
  input wire [7:0]  wdata,
  input wire        wr,
  input wire        rd,
  input wire [7:0]  rdata,
  input wire [15:0] dec_sample,
  input wire        dec_valid,
  input wire        dec_ready,
  input wire        dac_sys_clk,
  input wire        bit_clock_out,
  input wire        word_select_out,
  input wire        audio_data_out
);
  reg  [7:0] c0, c1;
  reg  [4:0] dv, nfall;
  reg  [8:0] hi_len;
  reg  [5:0] sc_len;
  reg        bc_q, ws_q;
  wire [3:0] hh   = c0[1] ? (c0[0] ? `ADSO_HALF_384_S32 : `ADSO_HALF_256_S32)
                          : (c0[0] ? `ADSO_HALF_384_S16 : `ADSO_HALF_256_S16);
  wire [8:0] half = hh * (dv + 9'h001);
  wire [4:0] last = c0[1] ? `ADSO_LAST_POS_S32 : `ADSO_LAST_POS_S16;
  // Shadow of the control writes
  always @(posedge mclk) begin
    if (sys_rst) begin
      c0 <= `ADSO_RST_CONTROL_0;
      c1 <= `ADSO_RST_CONTROL_1;
      dv <= `ADSO_RST_DIVIDER;
    end else if (wr && ce) begin
      if (addr == `ADSO_ADDR_CONTROL_0) c0 <= wdata;
      if (addr == `ADSO_ADDR_CONTROL_1) c1 <= wdata;
      if (addr == `ADSO_ADDR_DIVIDER) dv <= wdata[4:0];
    end
  end
  always @(posedge mclk) begin
    bc_q   <= bit_clock_out;
    ws_q   <= word_select_out;
    hi_len <= bit_clock_out ? hi_len + 9'h001 : 9'h000;
    sc_len <= dac_sys_clk ? sc_len + 6'h01 : 6'h00;
    if (sys_rst || !c1[0] || ws_q != word_select_out) nfall <= 5'h00;
    else if (bc_q && !bit_clock_out) nfall <= nfall + 5'h01;
  end
  // ----------------------------
  // Properties
  // ----------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence take_s; dec_valid && dec_ready && ce; endsequence
  sequence bc_fall_s; $fell(bit_clock_out) && c1[0]; endsequence
  mclk_half_a: assert property ($fell(dac_sys_clk) && c1[0] |-> sc_len == dv + 6'h01)
    else $error("master clock half period wrong");
  off_quiet_a: assert property (!c1[0] |=> !dac_sys_clk && !bit_clock_out && !audio_data_out)
    else $error("outputs active while interface off");
  ready_gate_a: assert property (dec_ready |-> c1[0] && !c1[7])
    else $error("decoder ready with wrong source");
  take_drop_a: assert property (take_s |=> !dec_ready)
    else $error("ready stayed high after a take");
  data_fall_a: assert property ($changed(audio_data_out) || $changed(word_select_out) |-> !bit_clock_out)
    else $error("data moved on rising bit clock");
  bclk_half_a: assert property (bc_fall_s |-> hi_len == half)
    else $error("bit clock high time wrong");
  ws_slot_a: assert property (bc_fall_s |-> $changed(word_select_out) == (nfall == last))
    else $error("word select off slot boundary");
  ws_left_a: assert property (!c1[0] |=> word_select_out == $past(c0[2]))
    else $error("idle word select not at left level");
endmodule // adso_top_asserts

bind adso_top adso_top_asserts u_chk (.mclk, .sys_rst, .ce, .addr, .wdata, .wr, .rd, .rdata,
  .dec_sample, .dec_valid, .dec_ready, .dac_sys_clk, .bit_clock_out, .word_select_out,
  .audio_data_out);

/* bench/adso_dac_model.sv */
`timescale 1ns/10ps
module adso_dac_model (
  input  wire        bit_clock_out,
  input  wire        word_select_out,
  input  wire        audio_data_out,
  output reg  [38:0] slot,
  output reg         slot_stb
);
  reg [31:0] sr  = 32'h0000_0000;
  reg [5:0]  nb  = 6'h00;
  reg        lvl = 1'b0;
  initial slot_stb = 1'b0;
  // Converter samples on the rising bit clock
  always @(posedge bit_clock_out) begin
    if (nb == 6'h00) begin
      lvl = word_select_out;
      sr  = 32'h0000_0000;
    end
    sr = {sr[30:0], audio_data_out};
    nb = nb + 6'h01;
  end
  // Slot closes when word select flips
  always @(word_select_out) begin
    if (nb != 6'h00) begin
      slot     = {nb, lvl, sr};
      nb       = 6'h00;
      slot_stb = !slot_stb;
    end
  end
endmodule // adso_dac_model

/* bench/adso_top_tb_top.sv */
`timescale 1ns/10ps
`include "adso_defs.vh"
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin mismatches++; $display("[FAIL] %0t got %h exp %h", $time, g, x); end end
module adso_top_tb_top;
  reg         mclk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         ce = 1'b1;
  reg  [7:0]  addr = 8'h00;
  reg  [7:0]  wdata = 8'h00;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg  [15:0] dec_sample = 16'h0000;
  reg         dec_valid = 1'b0;
  wire [7:0]  rdata;
  wire        dec_ready, dac_sys_clk, bit_clock_out, word_select_out, audio_data_out;
  wire [38:0] got;
  wire        got_stb;
  int         mismatches = 0;
  int         n_compared = 0;
  int         i, k;
  reg  [38:0] sq[$];
  reg  [7:0]  rq[$];
  reg  [38:0] e;
  reg  [7:0]  re;
  reg         rd_d = 1'b0;
  reg  [15:0] l, r;
  reg  [4:0]  jv;
  reg         src, drop;

  always #2 mclk = ~mclk;

  adso_top u_dut (.mclk, .sys_rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .dec_sample,
    .dec_valid, .dec_ready, .dac_sys_clk, .bit_clock_out, .word_select_out, .audio_data_out);
  adso_dac_model u_dac (.bit_clock_out, .word_select_out, .audio_data_out, .slot(got),
    .slot_stb(got_stb));

  // ----------------------------
  // Result watchers
  // ----------------------------
  always @(got_stb) if (!sys_rst) begin
    if (sq.size() == 0) begin
      mismatches++;
      $display("[FAIL] %0t unexpected slot", $time);
    end else begin
      e = sq.pop_front();
      `CHK(got, e)
    end
  end
  always @(posedge mclk) begin
    if (rd_d) begin
      re = rq.pop_front();
      `CHK(rdata, re)
    end
    rd_d <= rd;
  end

  function automatic [38:0] note(input [15:0] s, input [4:0] j, input wide, input lvl);
    reg [31:0] v;
    int p, n;
    n = wide ? 32 : 16;
    v = 32'h0000_0000;
    for (p = 0; p < n; p++)
      if (p >= j && p < j + 16) v[n-1-p] = s[15-(p-j)];
    note = {n[5:0], lvl, v};
  endfunction

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic tmo;
    mismatches++;
    $display("[FAIL] %0t wait timed out", $time);
    stop_test;
  endtask

  task automatic bus(input bit rdx, input [7:0] a, input [7:0] d);
    if (rdx) rq.push_back(d);
    addr  <= a;
    wdata <= rdx ? 8'h00 : d;
    wr    <= !rdx;
    rd    <= rdx;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic dsend(input [15:0] s);
    dec_sample <= s;
    dec_valid  <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (!dec_ready && k < 9000);
    if (k >= 9000) tmo;
    dec_valid <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic drain;
    k = 0;
    while (sq.size() != 0 && k < 20000) begin
      @(posedge mclk);
      k++;
    end
    if (sq.size() != 0) tmo;
    repeat (4) @(posedge mclk);
  endtask

  initial begin
    k = $urandom(32'hB7AD);
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    bus(1, `ADSO_ADDR_CONTROL_0, `ADSO_RST_CONTROL_0);
    bus(1, `ADSO_ADDR_CONTROL_1, `ADSO_RST_CONTROL_1);
    bus(1, 8'h55, 8'h00);
    bus(1, `ADSO_ADDR_SAMPLE_HI, 8'h00);
    bus(1, `ADSO_ADDR_STATUS, 8'h00);
    bus(1, `ADSO_ADDR_DIVIDER, 8'h00);
    // Every rate, width and polarity, at justifications 0, 16 and 1
    for (i = 0; i < 24; i++) begin
      jv = (i < 8) ? 5'h00 : (i < 16) ? 5'h10 : 5'h01;
      src = i[2] ^ i[0];
      drop = !src && i[4];
      l = $urandom;
      r = $urandom;
      bus(0, `ADSO_ADDR_CONTROL_1, 8'h00);
      bus(0, `ADSO_ADDR_DIVIDER, 8'($urandom % 3));
      bus(0, `ADSO_ADDR_CONTROL_0, {jv, i[2:0]});
      bus(0, `ADSO_ADDR_CONTROL_1, {src, 7'h01});
      bus(1, `ADSO_ADDR_CONTROL_0, {jv, i[2:0]});
      bus(1, `ADSO_ADDR_CONTROL_1, {src, 7'h01});
      sq.push_back(note(l, jv, i[1], i[2]));
      sq.push_back(note(drop ? 16'h0000 : r, jv, i[1], !i[2]));
      if (src) begin
        bus(0, `ADSO_ADDR_SAMPLE_LO, l[7:0]);
        bus(1, `ADSO_ADDR_SAMPLE_LO, l[7:0]);
        bus(0, `ADSO_ADDR_SAMPLE_HI, l[15:8]);
        k = 0;
        while (!bit_clock_out && k < 9000) begin
          @(posedge mclk);
          k++;
        end
        if (!bit_clock_out) tmo;
        bus(1, `ADSO_ADDR_STATUS, 8'h02);
        bus(0, `ADSO_ADDR_SAMPLE_LO, r[7:0]);
        bus(0, `ADSO_ADDR_SAMPLE_HI, r[15:8]);
        bus(1, `ADSO_ADDR_STATUS, 8'h03);
      end else begin
        bus(0, `ADSO_ADDR_SAMPLE_HI, 8'hA5);
        dsend(l);
        if (!drop) dsend(r);
      end
      drain;
    end
    stop_test;
  end
endmodule // adso_top_tb_top
